// >>> hdl/block_cipher_mode_encipher.sv
// Top: pads, blocks and chains a byte message through the cipher core
// Notes on behaviour
// RQ1 - 64-bit core, codebook or chaining per operation
// RQ2 - Any-length message and session key, one operation
// RQ3 - Ragged tail gets 0x80 then zero bytes
// RQ4 - Aligned message padding chosen by host setting
// RQ5 - Full-pad adds block 0x80 plus seven zeros
// RQ6 - Eight-byte blocks processed in message order
// RQ7 - Codebook: each block enciphered on its own
// RQ8 - Chaining: XOR previous cipher block, zero start
// RQ9 - Decipher inverts, unchains, strips the padding only when full-pad is set
// RQ10 - Byte handshake in, ordered blocks out, last flagged
`timescale 1ns/1ps
module block_cipher_mode_encipher (
   // Clock and reset
   input  wire logic                      mclk_i,
   input  wire logic                      rst_n_i,
   // Operation settings and session key, held for the whole message
   input  wire blk_mode_pkg::op_cfg_t     cfg_i,
   input  wire logic [127:0]              encipherment_session_key_i,
   // Input message byte stream
   input  wire logic                      in_valid_i,
   input  wire blk_mode_pkg::byte_beat_t  input_message_i,
   output logic                           in_ready_o,
   // Result blocks
   output logic                           out_valid_o,
   output blk_mode_pkg::block_beat_t      out_block_o,
   output logic [3:0]                     out_keep_o
);
   // ======================================================
   // State machine
   typedef enum logic [3:0] {
      ST_FILL = 4'b0001,    // Gathering message bytes
      ST_PAD  = 4'b0010,    // Inserting pad bytes
      ST_RUN  = 4'b0100,    // Core taking in a block
      ST_WAIT = 4'b1000     // Core result pending
   } phase_t;

   phase_t       phase;       // Current phase
   phase_t       next_phase;
   logic [63:0]  gather;      // Block being assembled, first byte leftmost
   logic [63:0]  next_gather;
   logic [2:0]   lane;        // Next byte position
   logic [2:0]   next_lane;
   logic [63:0]  chain;       // Previous cipher block, zero at start
   logic [63:0]  next_chain;
   logic         final_blk;   // Block in flight is the last one
   logic         next_final;
   logic         tail_pad;    // Pad block still owed after aligned end
   logic         next_tail;
   logic         start;       // Core launch
   logic         next_start;
   logic         next_in_ready;
   logic         next_out_valid;
   blk_mode_pkg::block_beat_t next_out;
   logic [3:0]   next_out_keep;
   logic         core_done;
   logic [63:0]  core_out;

   // Place one byte into its lane of a block
   function automatic logic [63:0] put_byte(input logic [63:0] blk, input logic [2:0] pos,
                                            input logic [7:0] b);
      logic [63:0] r;
      r = blk;
      r[8*(blk_mode_pkg::LAST_LANE - pos) +: 8] = b;
      put_byte = r;
   endfunction : put_byte

   // Count bytes before the 0x80 marker, scanning from the right
   function automatic logic [3:0] strip_len(input logic [63:0] blk);
      logic [3:0] n;
      logic       seen;
      n    = 4'h8;
      seen = 1'b0;
      for (int i = 0; i < blk_mode_pkg::BLOCK_BYTES; i++) begin
         if (!seen && blk[8*i +: 8] == blk_mode_pkg::PAD_MARK) begin
            n    = 4'(7 - i);
            seen = 1'b1;
         end else if (!seen && blk[8*i +: 8] != blk_mode_pkg::PAD_ZERO) begin
            seen = 1'b1;
         end
      end
      strip_len = n;
   endfunction : strip_len

   // ======================================================
   // Cipher core
   block_cipher_core u_core (
      .mclk_i     (mclk_i),
      .rst_n_i    (rst_n_i),
      .start_i    (start),
      .decipher_i (cfg_i.decipher),
      .block_i    ((cfg_i.mode == blk_mode_pkg::MODE_CHAIN && !cfg_i.decipher) ?
                   (gather ^ chain) : gather),                          // RQ8 RQ7
      .key_i      (encipherment_session_key_i),
      .done_o     (core_done),
      .block_o    (core_out)
   );

   // ======================================================
   // Next-state logic
   always_comb begin
      logic [63:0] res;
      res            = 64'h0000_0000_0000_0000;
      next_phase     = phase;
      next_gather    = gather;
      next_lane      = lane;
      next_chain     = chain;
      next_final     = final_blk;
      next_tail      = tail_pad;
      next_start     = 1'b0;
      next_in_ready  = in_ready_o;
      next_out_valid = 1'b0;
      next_out       = out_block_o;
      next_out_keep  = out_keep_o;
      unique case (phase)
         ST_FILL: begin
            if (in_valid_i && in_ready_o) begin
               // RQ10
               next_gather = put_byte(gather, lane, input_message_i.data); // RQ6
               next_lane   = 3'(lane + 3'h1);
               if (input_message_i.last) begin
                  next_in_ready = 1'b0;
                  if (lane != blk_mode_pkg::LAST_LANE) begin
                     next_gather = put_byte(next_gather, next_lane, blk_mode_pkg::PAD_MARK); // RQ3
                     next_lane   = 3'(lane + 3'h2);
                     next_final  = 1'b1;
                     next_phase  = (lane == 3'h6) ? ST_RUN : ST_PAD;
                     next_start  = (lane == 3'h6);
                  end else begin
                     next_tail  = cfg_i.full_pad && !cfg_i.decipher;          // RQ4 RQ5
                     next_final = !next_tail;
                     next_phase = ST_RUN;
                     next_start = 1'b1;
                  end
               end else if (lane == blk_mode_pkg::LAST_LANE) begin
                  next_in_ready = 1'b0;
                  next_phase    = ST_RUN;
                  next_start    = 1'b1;
               end
            end
         end
         ST_PAD: begin
            // Zero fill up to the block boundary
            next_gather = put_byte(gather, lane, blk_mode_pkg::PAD_ZERO);      // RQ3
            next_lane   = 3'(lane + 3'h1);
            if (lane == blk_mode_pkg::LAST_LANE) begin
               next_phase = ST_RUN;
               next_start = 1'b1;
            end
         end
         ST_RUN: begin
            // Core takes the block this cycle
            next_phase = ST_WAIT;
         end
         ST_WAIT: begin
            if (core_done) begin
               if (cfg_i.decipher) begin
                  res = (cfg_i.mode == blk_mode_pkg::MODE_CHAIN) ? (core_out ^ chain) : core_out; // RQ9
                  next_chain = gather;
               end else begin
                  res        = core_out;                                        // RQ1
                  next_chain = core_out;
               end
               next_out_valid   = 1'b1;
               next_out.data    = res;
               next_out.last    = final_blk;                                    // RQ10
               next_out_keep    = (final_blk && cfg_i.decipher && cfg_i.full_pad) ?
                                  strip_len(res) : 4'h8;                        // RQ9
               next_gather      = 64'h0000_0000_0000_0000;
               next_lane        = 3'h0;
               if (tail_pad) begin
                  // Extra whole pad block after an aligned message
                  next_gather = put_byte(64'h0000_0000_0000_0000, 3'h0, blk_mode_pkg::PAD_MARK); // RQ5
                  next_tail   = 1'b0;
                  next_final  = 1'b1;
                  next_phase  = ST_RUN;
                  next_start  = 1'b1;
               end else begin
                  if (final_blk)
                     next_chain = blk_mode_pkg::ZERO_IV;                       // RQ8 RQ2
                  next_final    = 1'b0;
                  next_in_ready = 1'b1;
                  next_phase    = ST_FILL;
               end
            end
         end
         default: begin
            next_phase    = ST_FILL;
            next_in_ready = 1'b1;
         end
      endcase
   end

   // ======================================================
   // Registers
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         phase       <= ST_FILL;
         gather      <= 64'h0000_0000_0000_0000;
         lane        <= 3'h0;
         chain       <= 64'h0000_0000_0000_0000;
         final_blk   <= 1'b0;
         tail_pad    <= 1'b0;
         start       <= 1'b0;
         in_ready_o  <= 1'b1;
         out_valid_o <= 1'b0;
         out_block_o <= '0;
         out_keep_o  <= 4'h8;
      end else begin
         phase       <= next_phase;
         gather      <= next_gather;
         lane        <= next_lane;
         chain       <= next_chain;
         final_blk   <= next_final;
         tail_pad    <= next_tail;
         start       <= next_start;
         in_ready_o  <= next_in_ready;
         out_valid_o <= next_out_valid;
         out_block_o <= next_out;
         out_keep_o  <= next_out_keep;
      end
   end
endmodule : block_cipher_mode_encipher

// >>> hdl/blk_mode_pkg.sv
// Package: shared constants and carriers for the block cipher mode wrapper
package blk_mode_pkg;
   // ======================================================
   // Block geometry
   localparam int BLOCK_BITS  = 64;
   localparam int BLOCK_BYTES = 8;
   localparam int KEY_BITS    = 128;
   localparam int ROUNDS      = 16;
   localparam logic [2:0] LAST_LANE = 3'h7;
   // ======================================================
   // Padding bytes, zero chaining start value and last round index
   localparam logic [7:0] PAD_MARK = 8'h80;
   localparam logic [7:0] PAD_ZERO = 8'h00;
   localparam logic [63:0] ZERO_IV = 64'h0000_0000_0000_0000;
   localparam logic [4:0] ROUND_LAST = 5'h0f;
   // ======================================================
   // Chaining modes
   typedef enum logic {
      MODE_CODEBOOK = 1'b0,
      MODE_CHAIN    = 1'b1
   } chain_mode_t;

   // Byte stream carrier from the host
   typedef struct packed {
      logic [7:0] data;
      logic       last;
   } byte_beat_t;

   // Cipher block carrier toward the user
   typedef struct packed {
      logic [63:0] data;
      logic        last;
   } block_beat_t;

   // Per-operation settings, fixed before the first byte
   typedef struct packed {
      chain_mode_t mode;
      logic        full_pad;
      logic        decipher;
   } op_cfg_t;
endpackage : blk_mode_pkg

// >>> hdl/block_cipher_core.sv
// Iterative 64-bit Feistel block cipher core, one round per clock
`timescale 1ns/1ps
module block_cipher_core (
   // Clock and reset
   input  wire logic         mclk_i,
   input  wire logic         rst_n_i,
   // Request
   input  wire logic         start_i,
   input  wire logic         decipher_i,
   input  wire logic [63:0]  block_i,
   input  wire logic [127:0] key_i,
   // Result
   output logic              done_o,
   output logic [63:0]       block_o
);
   // ======================================================
   // State
   logic [31:0]  left;       // Left half
   logic [31:0]  right;      // Right half
   logic [4:0]   round;      // Round counter
   logic         busy;       // Rounds in flight
   logic         dir;        // Direction latched at start
   logic [31:0]  next_left;
   logic [31:0]  next_right;
   logic [4:0]   next_round;
   logic         next_busy;
   logic         next_dir;
   logic         next_done;

   // Round function; the schedule is a rotation of the key so that
   // decipherment only walks the round index backwards.
   function automatic logic [31:0] round_f(input logic [31:0] r, input logic [127:0] k,
                                           input logic [3:0] idx);
      logic [31:0] sub;
      sub = k[32*idx[1:0] +: 32] ^ {idx, idx, idx, idx, idx, idx, idx, idx};
      round_f = ({r[26:0], r[31:27]} + sub) ^ {r[7:0], r[31:8]};
   endfunction : round_f

   // ======================================================
   // Next state
   always_comb begin
      logic [3:0] idx;
      idx        = 4'h0;
      next_left  = left;
      next_right = right;
      next_round = round;
      next_busy  = busy;
      next_dir   = dir;
      next_done  = 1'b0;
      if (start_i && !busy) begin
         // Load input block halves, plaintext or ciphertext
         next_left  = block_i[63:32];
         next_right = block_i[31:0];
         next_round = 5'h00;
         next_busy  = 1'b1;
         next_dir   = decipher_i;
      end else if (busy) begin
         idx        = dir ? 4'(blk_mode_pkg::ROUND_LAST - round) : round[3:0];
         next_left  = right;
         next_right = left ^ round_f(right, key_i, idx);
         next_round = 5'(round + 5'h01);
         if (round == blk_mode_pkg::ROUND_LAST) begin
            // Final swap undone so the inverse is the same network
            next_left  = left ^ round_f(right, key_i, idx);
            next_right = right;
            next_busy  = 1'b0;
            next_done  = 1'b1;
         end
      end
   end

   // Registers
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         left   <= 32'h0000_0000;
         right  <= 32'h0000_0000;
         round  <= 5'h00;
         busy   <= 1'b0;
         dir    <= 1'b0;
         done_o <= 1'b0;
      end else begin
         left   <= next_left;
         right  <= next_right;
         round  <= next_round;
         busy   <= next_busy;
         dir    <= next_dir;
         done_o <= next_done;
      end
   end

   assign block_o = {left, right};
endmodule : block_cipher_core

// >>> verification/blk_mode_monitor.sv
// Checker for the block cipher mode wrapper, bound to its top module
`timescale 1ns/1ps
module blk_mode_monitor (
   // Clock and reset
   input wire logic                      mclk_i,
   input wire logic                      rst_n_i,
   // Watched ports
   input wire blk_mode_pkg::op_cfg_t     cfg_i,
   input wire logic                      in_valid_i,
   input wire blk_mode_pkg::byte_beat_t  input_message_i,
   input wire logic                      in_ready_o,
   input wire logic                      out_valid_o,
   input wire blk_mode_pkg::block_beat_t out_block_o,
   input wire logic [3:0]                out_keep_o
);
   // ==========================================
   // Helper counters
   logic        acc;                // Byte taken at this edge
   logic        blk_end;            // That byte closes a block or the message
   logic [15:0] nbyte, next_nbyte;  // Bytes taken in the open message
   logic [15:0] nout, next_nout;    // Result blocks seen in the open message
   logic [15:0] nexp, next_nexp;    // Blocks owed for the message just closed
   logic [15:0] n1;                 // Message length including this byte

   assign acc     = in_valid_i && in_ready_o;
   assign blk_end = acc && (nbyte[2:0] == 3'h7 || input_message_i.last);
   assign n1      = nbyte + 16'h0001;

   // Next values; an aligned enciphered message with full padding owes one more block
   always_comb begin
      next_nbyte = acc ? (input_message_i.last ? 16'h0000 : n1) : nbyte;
      next_nout  = out_valid_o ? (out_block_o.last ? 16'h0000 : nout + 16'h0001) : nout;
      next_nexp  = nexp;
      if (acc && input_message_i.last) begin
         next_nexp = ((n1 + 16'h0007) >> 3) + 16'((n1[2:0] == 3'h0) && cfg_i.full_pad && !cfg_i.decipher);
      end
   end

   // Register the counters only
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         nbyte <= 16'h0000;
         nout  <= 16'h0000;
         nexp  <= 16'h0000;
      end else begin
         nbyte <= next_nbyte;
         nout  <= next_nout;
         nexp  <= next_nexp;
      end
   end

   // ==========================================
   // Assertions
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);

   property p_pulse; out_valid_o |=> !out_valid_o; endproperty
   a_pulse: assert property (p_pulse) else $error("result strobe longer than one cycle");
   property p_busy; blk_end |=> !in_ready_o; endproperty
   a_busy: assert property (p_busy) else $error("byte accepted while block in work");
   property p_answer; blk_end |-> ##[2:60] out_valid_o; endproperty
   a_answer: assert property (p_answer) else $error("no result after a full block");
   property p_ready_back; out_valid_o && out_block_o.last |=> in_ready_o; endproperty
   a_ready_back: assert property (p_ready_back) else $error("not ready after final block");
   property p_keep; out_valid_o && (!cfg_i.decipher || !out_block_o.last) |-> out_keep_o == 4'h8; endproperty
   a_keep: assert property (p_keep) else $error("byte count wrong on full block");
   property p_hold; !out_valid_o |-> $stable(out_block_o); endproperty
   a_hold: assert property (p_hold) else $error("result block changed without strobe");
   // Ready comes back on the same edge that raises the result strobe
   property p_rise; $rose(in_ready_o) |-> out_valid_o; endproperty
   a_rise: assert property (p_rise) else $error("ready returned without a result");
   property p_count; out_valid_o && out_block_o.last |-> nout + 16'h0001 == nexp; endproperty
   a_count: assert property (p_count) else $error("block count of message wrong");
endmodule : blk_mode_monitor

bind block_cipher_mode_encipher blk_mode_monitor u_monitor (
   .mclk_i(mclk_i), .rst_n_i(rst_n_i), .cfg_i(cfg_i), .in_valid_i(in_valid_i),
   .input_message_i(input_message_i), .in_ready_o(in_ready_o), .out_valid_o(out_valid_o),
   .out_block_o(out_block_o), .out_keep_o(out_keep_o)
);

// >>> verification/blk_host_model.sv
// Host-side model: feeds message bytes over the valid/ready handshake
`timescale 1ns/1ps
module blk_host_model (
   // Clock
   input  wire logic                 mclk_i,
   // Handshake toward the wrapper
   input  wire logic                 ready_i,
   output logic                      valid_o,
   output blk_mode_pkg::byte_beat_t  beat_o
);
   // ==========================================
   // Pending bytes
   logic [7:0] byte_q[$];  // Bytes not yet taken
   logic       took;       // Byte accepted at this edge

   // Queue a whole message; the last flag follows the final byte
   task automatic load(input logic [7:0] m[$]);
      foreach (m[i]) byte_q.push_back(m[i]);
   endtask : load

   initial begin
      valid_o = 1'b0;
      beat_o  = '0;
   end

   // Drive just after each edge; random gaps exercise a slow host
   always @(posedge mclk_i) begin
      took = valid_o && ready_i;
      if (took) void'(byte_q.pop_front());
      #1;
      if (valid_o && !took) begin
         valid_o = 1'b1;
      end else if (byte_q.size() != 0 && $urandom_range(3) != 0) begin
         valid_o     = 1'b1;
         beat_o.data = byte_q[0];
         beat_o.last = (byte_q.size() == 1);
      end else begin
         // Released: invert so a stale byte never looks current
         valid_o     = 1'b0;
         beat_o.data = ~beat_o.data;
         beat_o.last = ~beat_o.last;
      end
   end
endmodule : blk_host_model

// >>> verification/block_cipher_mode_encipher_tb.sv
// Self-checking bench for the block cipher mode wrapper
`timescale 1ns/1ps
module block_cipher_mode_encipher_tb;
   // ==========================================
   // Signals and bench state
   logic                      mclk_i, rst_n_i;       // Clock and reset
   blk_mode_pkg::op_cfg_t     cfg;                   // Held per message
   logic [127:0]              key;                   // Session key
   logic                      in_valid, in_ready, out_valid;
   blk_mode_pkg::byte_beat_t  in_beat;               // Byte from host
   blk_mode_pkg::block_beat_t out_beat;              // Result block
   logic [3:0]                keep;                  // Valid bytes of result
   logic [63:0]               res_q[$];              // Results of last run
   logic                      last_seen;             // Final block seen
   logic [3:0]                last_keep;             // Byte count of final block
   int                        err_count, check_count;

   initial begin
      mclk_i = 1'b0;
      forever #12.5 mclk_i = ~mclk_i;
   end

   block_cipher_mode_encipher uut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .cfg_i(cfg),
      .encipherment_session_key_i(key), .in_valid_i(in_valid), .input_message_i(in_beat),
      .in_ready_o(in_ready), .out_valid_o(out_valid), .out_block_o(out_beat), .out_keep_o(keep));
   blk_host_model host (.mclk_i(mclk_i), .ready_i(in_ready), .valid_o(in_valid), .beat_o(in_beat));

   // Collect every result pulse once outputs have settled
   always @(posedge mclk_i) begin
      #2;
      if (out_valid === 1'b1) begin
         res_q.push_back(out_beat.data);
         last_keep = keep;
         if (out_beat.last === 1'b1) last_seen = 1'b1;
      end
   end

   // ==========================================
   // Tasks
   task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   // Reference padding and blocking, first byte most significant
   function automatic void pad_msg(input logic [7:0] m[$], input logic fp, output logic [63:0] p[$]);
      logic [7:0]  b[$];
      logic [63:0] w;
      b = m;
      if (b.size() % 8 != 0 || fp) begin
         b.push_back(8'h80);
         while (b.size() % 8 != 0) b.push_back(8'h00);
      end
      p.delete();
      for (int i = 0; i < b.size(); i++) begin
         w = {w[55:0], b[i]};
         if (i % 8 == 7) p.push_back(w);
      end
   endfunction : pad_msg

   // One operation; settings stay fixed until the final block returns
   task automatic run(input logic [7:0] m[$], input logic md, input logic fp, input logic dc);
      int t;
      cfg.mode     = blk_mode_pkg::chain_mode_t'(md);
      cfg.full_pad = fp;
      cfg.decipher = dc;
      res_q.delete();
      last_seen = 1'b0;
      host.load(m);
      t = 0;
      while (last_seen !== 1'b1 && t < 3000) begin
         @(posedge mclk_i);
         t++;
      end
      if (last_seen !== 1'b1) chk("final_block", 64'h0, 64'h1);
      repeat (2) @(posedge mclk_i);
      #1;
   endtask : run

   // Encipher, then decipher the result and compare with the padded message
   task automatic rt(input logic [7:0] m[$], input logic md, input logic fp);
      logic [63:0] p[$];
      logic [7:0]  c[$];
      pad_msg(m, fp, p);
      run(m, md, fp, 1'b0);
      chk("blocks", 64'(res_q.size()), 64'(p.size()));
      foreach (res_q[i]) for (int j = 7; j >= 0; j--) c.push_back(res_q[i][j*8+:8]);
      run(c, md, fp, 1'b1);
      foreach (p[i]) chk("plain", res_q[i], p[i]);
      chk("keep", 64'(last_keep), fp ? 64'(m.size() % 8) : 64'h8);
   endtask : rt

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : give_verdict

   // Watchdog sized well above the expected run of a few thousand cycles
   initial begin
      repeat (60000) @(posedge mclk_i);
      err_count++;
      $display("BAD watchdog expected done seen hang");
      give_verdict();
   end

   // ==========================================
   // Main sequence
   initial begin
      logic [7:0]  m[$];
      logic [63:0] e1, c1;
      logic [7:0]  m2[$];
      int          lens[6] = '{1, 7, 8, 9, 16, 23};
      rst_n_i = 1'b0;
      cfg = '0;
      key = '0;
      err_count = 0;
      check_count = 0;
      void'($urandom(32'h3848_8994));
      repeat (3) @(posedge mclk_i);
      #1 rst_n_i = 1'b1;
      // Every mode and padding choice across ragged and aligned lengths
      foreach (lens[l]) for (int md = 0; md < 2; md++) for (int fp = 0; fp < 2; fp++) begin
         key = {$urandom, $urandom, $urandom, $urandom};
         m.delete();
         repeat (lens[l]) m.push_back(8'($urandom));
         rt(m, md[0], fp[0]);
      end
      $display("test round_trip done");
      // Twin blocks: codebook repeats, chaining starts from zero and restarts
      m.delete();
      repeat (8) m.push_back(8'($urandom));
      m = {m, m};
      run(m, 1'b0, 1'b0, 1'b0);
      e1 = res_q[0];
      chk("ecb_twin", res_q[1], e1);
      run(m, 1'b1, 1'b0, 1'b0);
      chk("cbc_first", res_q[0], e1);
      c1 = res_q[1];
      run(m, 1'b1, 1'b0, 1'b0);
      chk("cbc_restart", res_q[1], c1);
      // Second chained block must be the codebook result of X2 xor Y1
      m2.delete();
      for (int i = 0; i < 8; i++) m2.push_back(m[i] ^ e1[8*(7-i) +: 8]);
      run(m2, 1'b0, 1'b0, 1'b0);
      chk("cbc_link", res_q[0], c1);
      $display("test chaining done");
      // The extra full-pad block equals the lone marker block
      m = m[0:7];
      run(m, 1'b0, 1'b1, 1'b0);
      c1 = res_q[1];
      m = '{8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
      run(m, 1'b0, 1'b0, 1'b0);
      chk("full_pad_blk", res_q[0], c1);
      $display("test full_pad done");
      give_verdict();
   end
endmodule : block_cipher_mode_encipher_tb
